/* File: hdl/pm_pkg.sv */
// Constants, tables and carrier types for the pin routing and port block.
// Contract
// - Bits 7,6 steer second timer ch5,ch4.
// - Bits 5,4 steer second timer ch3,ch2.
// - Bits 3,2 steer second timer ch1,ch0.
// - Bits 1,0 steer first timer ch1,ch0.
// - Reset routes to small-package pins.
// - Serial bits 7,6 place second UART.
// - Serial bits 5,4 place SCL, SDA.
// - Serial bits 3,2 place MISO, MOSI.
// - Serial bits 1,0 place SCK, SS.
// - First-UART bits 1,0 place transmit, receive.
// - Enabled peripheral overrides general-purpose port.
// - Reset: inputs, slew on, low drive, no pullup.
// - LCD pins full drive only in one mode.
// - Direction bit picks output or input buffer.
// - Digital function drives; direction picks read source.
// - Analog disables buffers; input reads zero.
// - Analog beats digital on the same pin.
// - Reads: pin for inputs, latch for outputs.
// - Reset clears data latches, not driven.
// - Analog function forces pullup off.

package pm_pkg;

   // -----------------------------------------------------------------
   // Sizes and address layout
   // -----------------------------------------------------------------
   localparam int PM_ADDR_W    = 6;
   localparam int PM_DATA_W    = 8;
   localparam int PM_NPORT     = 4;
   localparam int PM_NPIN      = 32;
   localparam int PM_NFN       = 18;
   localparam int PM_PIN_W     = 5;
   localparam int PM_KIND_LSB  = 0;
   localparam int PM_KIND_W    = 3;
   localparam int PM_PORT_LSB  = 3;
   localparam int PM_PORT_W    = 2;
   localparam int PM_SPACE_LSB = 5;

   // Register kinds within one port's group.
   localparam logic [2:0] PM_KIND_DATA  = 3'h0;
   localparam logic [2:0] PM_KIND_DIR   = 3'h1;
   localparam logic [2:0] PM_KIND_PULL  = 3'h2;
   localparam logic [2:0] PM_KIND_SLEW  = 3'h3;
   localparam logic [2:0] PM_KIND_DRIVE = 3'h4;

   // Routing register offsets and one port data offset.
   localparam logic [5:0] PM_OFS_TIMER_ROUTE    = 6'h20;
   localparam logic [5:0] PM_OFS_SERIAL_ROUTE   = 6'h21;
   localparam logic [5:0] PM_OFS_UART_ONE_ROUTE = 6'h22;
   localparam logic [5:0] PM_OFS_PORT_F_DATA    = 6'h08;

   // -----------------------------------------------------------------
   // Reset values and masks
   // -----------------------------------------------------------------
   localparam logic [7:0]  PM_DATA_RST   = 8'h00;
   localparam logic [7:0]  PM_DIR_RST    = 8'h00;
   localparam logic [7:0]  PM_PULL_RST   = 8'h00;
   localparam logic [7:0]  PM_SLEW_RST   = 8'hFF;
   localparam logic [7:0]  PM_DRIVE_RST  = 8'h00;
   localparam logic [7:0]  PM_ROUTE_RST  = 8'h00;
   localparam logic [7:0]  PM_UART_MASK  = 8'h03;
   localparam logic [1:0]  PM_UART_W_MSK = 2'h3;
   localparam logic [31:0] PM_LCD_PINS   = 32'h000000FF;
   localparam logic [1:0]  PM_SUPPLY_FULL = 2'h3;

   // -----------------------------------------------------------------
   // Function indices; index equals the bit in the joined route vector
   // -----------------------------------------------------------------
   localparam int PM_FN_T1C0 = 0,  PM_FN_T1C1 = 1,  PM_FN_T2C0 = 2;
   localparam int PM_FN_T2C1 = 3,  PM_FN_T2C2 = 4,  PM_FN_T2C3 = 5;
   localparam int PM_FN_T2C4 = 6,  PM_FN_T2C5 = 7,  PM_FN_SS   = 8;
   localparam int PM_FN_SCK  = 9,  PM_FN_MOSI = 10, PM_FN_MISO = 11;
   localparam int PM_FN_SDA  = 12, PM_FN_SCL  = 13, PM_FN_U2RX = 14;
   localparam int PM_FN_U2TX = 15, PM_FN_U1RX = 16, PM_FN_U1TX = 17;

   // Pin index is port*8+bit, ports in order A, F, H, I.
   localparam logic [4:0] PM_PIN_CLR [PM_NFN] = '{
      5'h09, 5'h0A, 5'h05, 5'h06, 5'h08, 5'h0D, 5'h0C, 5'h0B, 5'h0B,
      5'h0A, 5'h0D, 5'h0C, 5'h02, 5'h01, 5'h04, 5'h03, 5'h09, 5'h08};
   localparam logic [4:0] PM_PIN_SET [PM_NFN] = '{
      5'h15, 5'h14, 5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h1D,
      5'h1C, 5'h1B, 5'h1A, 5'h1C, 5'h1D, 5'h18, 5'h19, 5'h14, 5'h15};

   // -----------------------------------------------------------------
   // Carrier types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic oe;
      logic o;
   } pm_fn_drv_t;

   typedef struct packed {
      logic o;
      logic oe_n;
      logic pu;
      logic slew;
      logic hd;
   } pm_pad_t;

endpackage

/* File: hdl/pm_pin_router.sv */
// Pin routing, general-purpose port registers and pad control logic.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module pm_pin_router #(
   parameter int ADDR_W = pm_pkg::PM_ADDR_W
) (
   input  wire logic                                  clk,
   input  wire logic                                  nrst,
   input  wire logic [ADDR_W-1:0]                     addr,
   input  wire logic [pm_pkg::PM_DATA_W-1:0]          wdata,
   input  wire logic                                  we,
   input  wire logic                                  re,
   output var  logic [pm_pkg::PM_DATA_W-1:0]          rdata,
   input  wire logic [1:0]                            lcd_supply_select,
   input  wire logic                                  full_drive_enable,
   input  wire logic                                  regulator_enable,
   input  wire logic [pm_pkg::PM_NPIN-1:0]            analog_en,
   input  wire pm_pkg::pm_fn_drv_t [pm_pkg::PM_NFN-1:0] fn_drv,
   output var  logic [pm_pkg::PM_NFN-1:0]             fn_in,
   input  wire logic [pm_pkg::PM_NPIN-1:0]            pad_i,
   output var  pm_pkg::pm_pad_t [pm_pkg::PM_NPIN-1:0] pad
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (ADDR_W < pm_pkg::PM_ADDR_W) begin : g_bad_addr
      $error("Address width too small for the register map.");
   end

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [pm_pkg::PM_NPORT-1:0][7:0] data_reg;
   logic [pm_pkg::PM_NPORT-1:0][7:0] dir_reg;
   logic [pm_pkg::PM_NPORT-1:0][7:0] pull_reg;
   logic [pm_pkg::PM_NPORT-1:0][7:0] slew_reg;
   logic [pm_pkg::PM_NPORT-1:0][7:0] drive_reg;
   logic [7:0]                       timer_route_reg;
   logic [7:0]                       serial_route_reg;
   logic [1:0]                       uart_one_route_reg;
   logic [7:0]                       rdata_reg;
   logic [7:0]                       rdata_next;

   logic [pm_pkg::PM_NPIN-1:0]       data_flat;
   logic [pm_pkg::PM_NPIN-1:0]       dir_flat;
   logic [pm_pkg::PM_NPIN-1:0]       pull_flat;
   logic [pm_pkg::PM_NPIN-1:0]       slew_flat;
   logic [pm_pkg::PM_NPIN-1:0]       drive_flat;
   logic [pm_pkg::PM_NPIN-1:0]       pin_in;
   logic [pm_pkg::PM_NPIN-1:0]       read_bit;
   logic [pm_pkg::PM_NFN-1:0]        route_vec;
   logic [pm_pkg::PM_PIN_W-1:0]      sel_pin [pm_pkg::PM_NFN];
   logic                             full_drive;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic [pm_pkg::PM_PORT_W-1:0] acc_port;
   logic [pm_pkg::PM_KIND_W-1:0] acc_kind;
   logic                         port_space;
   logic                         kind_ok;

   // Port groups sit below the routing registers; high bits must be zero.
   assign acc_port   = addr[pm_pkg::PM_PORT_LSB +: pm_pkg::PM_PORT_W];
   assign acc_kind   = addr[pm_pkg::PM_KIND_LSB +: pm_pkg::PM_KIND_W];
   assign port_space = (addr >> pm_pkg::PM_SPACE_LSB) == '0;
   assign kind_ok    = acc_kind <= pm_pkg::PM_KIND_DRIVE;

   assign data_flat  = data_reg;
   assign dir_flat   = dir_reg;
   assign pull_flat  = pull_reg;
   assign slew_flat  = slew_reg;
   assign drive_flat = drive_reg;

   // ----------------------------------------------------------------
   // Port registers
   // ----------------------------------------------------------------
   // Software writes update every bit of the addressed port register.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         data_reg  <= {pm_pkg::PM_NPORT{pm_pkg::PM_DATA_RST}};
         dir_reg   <= {pm_pkg::PM_NPORT{pm_pkg::PM_DIR_RST}};
         pull_reg  <= {pm_pkg::PM_NPORT{pm_pkg::PM_PULL_RST}};
         slew_reg  <= {pm_pkg::PM_NPORT{pm_pkg::PM_SLEW_RST}};
         drive_reg <= {pm_pkg::PM_NPORT{pm_pkg::PM_DRIVE_RST}};
      end else if (we && port_space && kind_ok) begin
         unique case (acc_kind)
            pm_pkg::PM_KIND_DATA:  data_reg[acc_port]  <= wdata;
            pm_pkg::PM_KIND_DIR:   dir_reg[acc_port]   <= wdata;
            pm_pkg::PM_KIND_PULL:  pull_reg[acc_port]  <= wdata;
            pm_pkg::PM_KIND_SLEW:  slew_reg[acc_port]  <= wdata;
            default:               drive_reg[acc_port] <= wdata;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Routing registers
   // ----------------------------------------------------------------
   // Routes reset to the small-package pins and take effect next cycle.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         timer_route_reg    <= pm_pkg::PM_ROUTE_RST;
         serial_route_reg   <= pm_pkg::PM_ROUTE_RST;
         uart_one_route_reg <= '0;
      end else if (we) begin
         if (addr == ADDR_W'(pm_pkg::PM_OFS_TIMER_ROUTE)) begin
            timer_route_reg <= wdata;
         end
         if (addr == ADDR_W'(pm_pkg::PM_OFS_SERIAL_ROUTE)) begin
            serial_route_reg <= wdata;
         end
         if (addr == ADDR_W'(pm_pkg::PM_OFS_UART_ONE_ROUTE)) begin
            uart_one_route_reg <= wdata[1:0] & pm_pkg::PM_UART_W_MSK;
         end
      end
   end

   // The three routing registers joined in function-index order.
   assign route_vec = {uart_one_route_reg, serial_route_reg,
                       timer_route_reg};

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Selects the addressed register; unmapped addresses read zero.
   always_comb begin
      rdata_next = '0;
      if (port_space && kind_ok) begin
         unique case (acc_kind)
            pm_pkg::PM_KIND_DATA:  rdata_next = read_bit[
                                      {acc_port, 3'h0} +: 8];
            pm_pkg::PM_KIND_DIR:   rdata_next = dir_reg[acc_port];
            pm_pkg::PM_KIND_PULL:  rdata_next = pull_reg[acc_port];
            pm_pkg::PM_KIND_SLEW:  rdata_next = slew_reg[acc_port];
            default:               rdata_next = drive_reg[acc_port];
         endcase
      end else if (addr == ADDR_W'(pm_pkg::PM_OFS_TIMER_ROUTE)) begin
         rdata_next = timer_route_reg;
      end else if (addr == ADDR_W'(pm_pkg::PM_OFS_SERIAL_ROUTE)) begin
         rdata_next = serial_route_reg;
      end else if (addr == ADDR_W'(pm_pkg::PM_OFS_UART_ONE_ROUTE)) begin
         rdata_next = {6'h00, uart_one_route_reg} & pm_pkg::PM_UART_MASK;
      end
   end

   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_reg <= '0;
      end else if (re) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= '0;
      end
   end

   assign rdata = rdata_reg;

   // ----------------------------------------------------------------
   // Function placement
   // ----------------------------------------------------------------
   // LCD-shared pins drive both levels only in the external-supply mode.
   assign full_drive = (lcd_supply_select == pm_pkg::PM_SUPPLY_FULL) &&
                       full_drive_enable && !regulator_enable;

   // Each function picks its pin and hears that pin's gated input.
   for (genvar f = 0; f < pm_pkg::PM_NFN; f++) begin : g_fn
      assign sel_pin[f] = route_vec[f] ? pm_pkg::PM_PIN_SET[f]
                                       : pm_pkg::PM_PIN_CLR[f];
      assign fn_in[f]   = pin_in[sel_pin[f]];
   end

   // ----------------------------------------------------------------
   // Per-pin pad control
   // ----------------------------------------------------------------
   for (genvar p = 0; p < pm_pkg::PM_NPIN; p++) begin : g_pin
      logic own;
      logic own_oe;
      logic own_o;
      logic want;
      logic val;
      logic odrain;

      // Lowest-index enabled function routed here owns the output.
      always_comb begin
         own    = 1'b0;
         own_oe = 1'b0;
         own_o  = 1'b0;
         for (int f = pm_pkg::PM_NFN - 1; f >= 0; f--) begin
            if (fn_drv[f].en && sel_pin[f] == pm_pkg::PM_PIN_W'(p)) begin
               own    = 1'b1;
               own_oe = fn_drv[f].oe;
               own_o  = fn_drv[f].o;
            end
         end
      end

      // Analog wins over a digital function, which wins over the port.
      assign want   = analog_en[p] ? 1'b0 :
                      own ? own_oe :
                      dir_flat[p];
      assign val    = own ? own_o : data_flat[p];
      assign odrain = PM_LCD_BIT(p) && !full_drive;

      // Open drain only ever pulls low; the pullup stays for it.
      always_comb begin
         pad[p].o    = odrain ? 1'b0 : val;
         pad[p].oe_n = odrain ? !(want && !val) : !want;
         pad[p].pu   = pull_flat[p] && !analog_en[p] &&
                       !(want && !odrain);
         pad[p].slew = slew_flat[p];
         pad[p].hd   = drive_flat[p];
      end

      // Input buffer is off under analog, and off for a port output.
      assign pin_in[p]   = pad_i[p] && !analog_en[p] &&
                           (own || !dir_flat[p]);
      assign read_bit[p] = dir_flat[p] ? data_flat[p]
                                       : pin_in[p];
   end

   // Marks the pins that share the LCD and so default to open drain.
   function automatic logic PM_LCD_BIT(input int idx);
      PM_LCD_BIT = pm_pkg::PM_LCD_PINS[idx];
   endfunction

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Reset leaves routes cleared, pins input, latches zero, slew on.
   reset_defaults_a: assert property (
      @(posedge clk) $rose(nrst) |-> route_vec == '0 && dir_reg == '0 &&
         data_reg == '0 && pull_reg == '0 && drive_reg == '0 &&
         slew_reg == {pm_pkg::PM_NPORT{pm_pkg::PM_SLEW_RST}})
      else $error("Port or route state wrong after reset.");

   // Second timer channel 5 reaches its upper pin when routed there.
   route_t2c5_a: assert property (
      @(posedge clk) disable iff (!nrst)
      route_vec[pm_pkg::PM_FN_T2C5] && fn_drv[pm_pkg::PM_FN_T2C5].en &&
      fn_drv[pm_pkg::PM_FN_T2C5].oe &&
      !analog_en[pm_pkg::PM_PIN_SET[pm_pkg::PM_FN_T2C5]]
      |-> !pad[pm_pkg::PM_PIN_SET[pm_pkg::PM_FN_T2C5]].oe_n &&
          pad[pm_pkg::PM_PIN_SET[pm_pkg::PM_FN_T2C5]].o ==
          fn_drv[pm_pkg::PM_FN_T2C5].o)
      else $error("Timer channel 5 not on its routed pin.");

   // Second timer channel 3 reaches port I when routed there.
   route_t2c3_a: assert property (
      @(posedge clk) disable iff (!nrst)
      route_vec[pm_pkg::PM_FN_T2C3] && fn_drv[pm_pkg::PM_FN_T2C3].en &&
      fn_drv[pm_pkg::PM_FN_T2C3].oe &&
      !analog_en[pm_pkg::PM_PIN_SET[pm_pkg::PM_FN_T2C3]]
      |-> !pad[pm_pkg::PM_PIN_SET[pm_pkg::PM_FN_T2C3]].oe_n &&
          pad[pm_pkg::PM_PIN_SET[pm_pkg::PM_FN_T2C3]].o ==
          fn_drv[pm_pkg::PM_FN_T2C3].o)
      else $error("Timer channel 3 not on its routed pin.");

   // First timer channel 0 input follows its default pin while its route bit is clear.
   route_t1c0_a: assert property (
      @(posedge clk) disable iff (!nrst)
      !route_vec[pm_pkg::PM_FN_T1C0] &&
      !analog_en[pm_pkg::PM_PIN_CLR[pm_pkg::PM_FN_T1C0]] &&
      !dir_flat[pm_pkg::PM_PIN_CLR[pm_pkg::PM_FN_T1C0]]
      |-> fn_in[pm_pkg::PM_FN_T1C0] ==
          pad_i[pm_pkg::PM_PIN_CLR[pm_pkg::PM_FN_T1C0]])
      else $error("Timer channel 0 input from wrong pin.");

   // Second UART receive hears port I pin 0 when routed there.
   route_u2rx_a: assert property (
      @(posedge clk) disable iff (!nrst)
      route_vec[pm_pkg::PM_FN_U2RX] && fn_drv[pm_pkg::PM_FN_U2RX].en &&
      !analog_en[pm_pkg::PM_PIN_SET[pm_pkg::PM_FN_U2RX]]
      |-> fn_in[pm_pkg::PM_FN_U2RX] ==
          pad_i[pm_pkg::PM_PIN_SET[pm_pkg::PM_FN_U2RX]])
      else $error("Second UART receive from wrong pin.");

   // Clock line of the I2C port drives port I pin 5 when routed there.
   route_scl_a: assert property (
      @(posedge clk) disable iff (!nrst)
      route_vec[pm_pkg::PM_FN_SCL] && fn_drv[pm_pkg::PM_FN_SCL].en &&
      fn_drv[pm_pkg::PM_FN_SCL].oe && !fn_drv[pm_pkg::PM_FN_T2C0].en &&
      !fn_drv[pm_pkg::PM_FN_SS].en &&
      !analog_en[pm_pkg::PM_PIN_SET[pm_pkg::PM_FN_SCL]]
      |-> pad[pm_pkg::PM_PIN_SET[pm_pkg::PM_FN_SCL]].o ==
          fn_drv[pm_pkg::PM_FN_SCL].o)
      else $error("I2C clock not on its routed pin.");

   // SPI data in uses port F pin 4 while its route bit is clear.
   route_miso_a: assert property (
      @(posedge clk) disable iff (!nrst)
      !route_vec[pm_pkg::PM_FN_MISO] && fn_drv[pm_pkg::PM_FN_MISO].en &&
      fn_drv[pm_pkg::PM_FN_MISO].oe && !fn_drv[pm_pkg::PM_FN_T2C4].en &&
      !analog_en[pm_pkg::PM_PIN_CLR[pm_pkg::PM_FN_MISO]]
      |-> !pad[pm_pkg::PM_PIN_CLR[pm_pkg::PM_FN_MISO]].oe_n)
      else $error("SPI data in not on its default pin.");

   // SPI clock lands on port I pin 4 when routed there.
   route_sck_a: assert property (
      @(posedge clk) disable iff (!nrst)
      route_vec[pm_pkg::PM_FN_SCK] && fn_drv[pm_pkg::PM_FN_SCK].en &&
      fn_drv[pm_pkg::PM_FN_SCK].oe && !fn_drv[pm_pkg::PM_FN_T2C1].en &&
      !analog_en[pm_pkg::PM_PIN_SET[pm_pkg::PM_FN_SCK]]
      |-> !pad[pm_pkg::PM_PIN_SET[pm_pkg::PM_FN_SCK]].oe_n)
      else $error("SPI clock not on its routed pin.");

   // First UART transmit drives port F pin 0 while its bit is clear.
   route_u1tx_a: assert property (
      @(posedge clk) disable iff (!nrst)
      !route_vec[pm_pkg::PM_FN_U1TX] && fn_drv[pm_pkg::PM_FN_U1TX].en &&
      fn_drv[pm_pkg::PM_FN_U1TX].oe && !fn_drv[pm_pkg::PM_FN_T2C2].en &&
      !analog_en[pm_pkg::PM_PIN_CLR[pm_pkg::PM_FN_U1TX]]
      |-> pad[pm_pkg::PM_PIN_CLR[pm_pkg::PM_FN_U1TX]].o ==
          fn_drv[pm_pkg::PM_FN_U1TX].o)
      else $error("First UART transmit not on its default pin.");

   // An LCD-shared pin never drives high outside full drive mode.
   lcd_open_drain_a: assert property (
      @(posedge clk) disable iff (!nrst)
      !full_drive |-> !(pad[0].o && !pad[0].oe_n) &&
                      !(pad[7].o && !pad[7].oe_n))
      else $error("LCD-shared pin drove high in open drain mode.");

   // Analog pins float, lose the pullup and read zero as inputs.
   analog_pin_a: assert property (
      @(posedge clk) disable iff (!nrst)
      analog_en[pm_pkg::PM_NPIN-1] && !dir_flat[pm_pkg::PM_NPIN-1]
      |-> pad[pm_pkg::PM_NPIN-1].oe_n && !pad[pm_pkg::PM_NPIN-1].pu &&
          !read_bit[pm_pkg::PM_NPIN-1])
      else $error("Analog pin not released.");

   // A port F data read of an all-output port returns the latch.
   read_latch_a: assert property (
      @(posedge clk) disable iff (!nrst)
      re && addr == ADDR_W'(pm_pkg::PM_OFS_PORT_F_DATA) && &dir_reg[1]
      |=> rdata == $past(data_reg[1]))
      else $error("Port data read missed the latch.");

   // A routing write reads back and routes from the next cycle.
   route_write_a: assert property (
      @(posedge clk) disable iff (!nrst)
      we && addr == ADDR_W'(pm_pkg::PM_OFS_TIMER_ROUTE) ##1
      re && addr == ADDR_W'(pm_pkg::PM_OFS_TIMER_ROUTE)
      |=> rdata == $past(wdata, 2) && route_vec[7:0] == $past(wdata, 2))
      else $error("Timer route register did not read back.");

   // Read data falls back to zero in any cycle without a read strobe.
   rdata_idle_a: assert property (
      @(posedge clk) disable iff (!nrst)
      !re |=> rdata == '0)
      else $error("Read data stood without a read strobe.");

   // A pin that no function can reach follows its direction and latch.
   port_buffer_a: assert property (
      @(posedge clk) disable iff (!nrst)
      !analog_en[15]
      |-> pad[15].oe_n == !dir_flat[15] && pad[15].o == data_flat[15])
      else $error("Port pin buffer ignores its direction bit.");

   // A function routed to an analog pin hears only zero.
   analog_fn_in_a: assert property (
      @(posedge clk) disable iff (!nrst)
      !route_vec[pm_pkg::PM_FN_T2C2] &&
      analog_en[pm_pkg::PM_PIN_CLR[pm_pkg::PM_FN_T2C2]]
      |-> !fn_in[pm_pkg::PM_FN_T2C2])
      else $error("Function heard an analog pin.");

   // First UART receive hears port H pin 4 when routed there.
   route_u1rx_a: assert property (
      @(posedge clk) disable iff (!nrst)
      route_vec[pm_pkg::PM_FN_U1RX] && fn_drv[pm_pkg::PM_FN_U1RX].en &&
      !analog_en[pm_pkg::PM_PIN_SET[pm_pkg::PM_FN_U1RX]]
      |-> fn_in[pm_pkg::PM_FN_U1RX] ==
          pad_i[pm_pkg::PM_PIN_SET[pm_pkg::PM_FN_U1RX]])
      else $error("First UART receive from wrong pin.");

endmodule

`default_nettype wire

/* File: sim/pm_pin_model.sv */
// Pin model: resolves each package pin from the pad controls and the board.
`timescale 1ns/1ns
`default_nettype none

module pm_pin_model (
   input  wire pm_pkg::pm_pad_t [31:0] pad,
   input  wire logic [31:0]            ext,
   output var  logic [31:0]            pad_i
);
   // A driven pin shows its value, a pulled pin floats high, else the board.
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         if (!pad[i].oe_n) begin
            pad_i[i] = pad[i].o;
         end else if (pad[i].pu) begin
            pad_i[i] = 1'b1;
         end else begin
            pad_i[i] = ext[i];
         end
      end
   end
endmodule

`default_nettype wire

/* File: sim/test_pin_routing_and_port_io.sv */
// Testbench for the pin routing and port block.
`timescale 1ns/1ns
`default_nettype none

module test_pin_routing_and_port_io;
   logic                               clk = 1'b0, nrst = 1'b0;
   logic [5:0]                         addr = '0;
   logic [7:0]                         wdata = '0, rdata;
   logic                               we = 1'b0, re = 1'b0;
   logic [1:0]                         sup = '0;
   logic                               fde = 1'b0, rge = 1'b0;
   logic [31:0]                        ana = '0, ext = '0, pad_i;
   pm_pkg::pm_fn_drv_t [17:0]          fn_drv = '0;
   logic [17:0]                        fn_in;
   pm_pkg::pm_pad_t [31:0]             pad;
   int                                 err_total = 0, checked = 0, cyc = 0;

   pm_pin_router pm_pin_router_inst (.clk(clk), .nrst(nrst), .addr(addr),
      .wdata(wdata), .we(we), .re(re), .rdata(rdata),
      .lcd_supply_select(sup), .full_drive_enable(fde),
      .regulator_enable(rge), .analog_en(ana), .fn_drv(fn_drv),
      .fn_in(fn_in), .pad_i(pad_i), .pad(pad));
   pm_pin_model pm_pin_model_inst (.pad(pad), .ext(ext), .pad_i(pad_i));

   // Clock at 100 MHz.
   initial begin
      forever #5 clk = ~clk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Cuts a hang short.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         close_out;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Hold keeps the strobe up for a write that follows at once.
   task automatic wr(input logic [5:0] a, input logic [7:0] d,
                     input bit hold = 1'b0);
      addr <= a; wdata <= d; we <= 1'b1;
      @(posedge clk);
      if (!hold) begin
         we <= 1'b0;
      end
   endtask

   task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
      addr <= a; re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
      @(posedge clk);
   endtask

   task automatic t_reset;
      chk({pad[9].oe_n, pad[9].slew, pad[9].pu, pad[9].hd}, 4'hC);
      rdc(6'h0B, 8'hFF);
      rdc(6'h0A, 8'h00);
      rdc(6'h0C, 8'h00);
      rdc(6'h09, 8'h00);
      rdc(6'h20, 8'h00);
      rdc(6'h21, 8'h00);
      rdc(6'h05, 8'h00);
      $display("reset test done");
   endtask

   task automatic t_route;
      logic [17:0] rv;
      pm_pkg::pm_fn_drv_t [17:0] v;
      for (int s = 0; s < 2; s++) begin
         rv = s ? 18'h3FFFF : 18'h00000;
         wr(6'h21, rv[15:8], 1'b1);
         wr(6'h22, 8'hFF & {6'h00, rv[17:16]}, 1'b1);
         wr(6'h20, rv[7:0]);
         rdc(6'h20, rv[7:0]);
         rdc(6'h22, {6'h00, rv[17:16]});
         for (int i = 0; i < 18; i++) begin
            v = '0;
            v[i] = 3'b110;
            fn_drv <= v;
            @(negedge clk);
            chk(pad[s ? pm_pkg::PM_PIN_SET[i] : pm_pkg::PM_PIN_CLR[i]].oe_n,
                0);
            @(posedge clk);
         end
      end
      fn_drv <= '0;
      wr(6'h20, 8'h00, 1'b1);
      $display("route test done");
   endtask

   task automatic t_port;
      ext <= 32'h00005A00;
      wr(6'h08, 8'hC3);
      rdc(6'h08, 8'h5A);
      chk(fn_in[0], 1);
      wr(6'h09, 8'hFF);
      @(negedge clk);
      chk(pad_i[15:8], 8'hC3);
      @(posedge clk);
      rdc(6'h08, 8'hC3);
      fn_drv[4] <= 3'b110;
      rdc(6'h08, 8'hC3);
      chk(pad_i[8], 0);
      ana <= 32'h80000100;
      ext <= 32'hFFFFFFFF;
      wr(6'h0A, 8'hFF, 1'b1);
      wr(6'h09, 8'h00);
      @(negedge clk);
      chk({pad[8].oe_n, pad[8].pu, pad[9].pu}, 3'h5);
      @(posedge clk);
      rdc(6'h08, 8'hFE);
      ana <= '0;
      fn_drv <= '0;
      $display("port test done");
   endtask

   task automatic t_lcd;
      ext <= 32'h0;
      wr(6'h01, 8'hFF);
      rdc(6'h00, 8'h00);
      wr(6'h00, 8'hFF);
      @(negedge clk);
      chk(pad[0].oe_n, 1);
      @(posedge clk);
      sup <= 2'h3; fde <= 1'b1;
      @(negedge clk);
      chk({pad[0].oe_n, pad[0].o}, 2'h1);
      @(posedge clk);
      rge <= 1'b1;
      @(negedge clk);
      chk(pad[0].oe_n, 1);
      @(posedge clk);
      $display("lcd test done");
   endtask

   // Reset for five cycles, then the tests in turn.
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset;
      t_route;
      t_port;
      t_lcd;
      close_out;
   end
endmodule

`default_nettype wire
